// *** verilog/mode_reg_defines.vh ***
// Mode register addresses, field positions, reset values and codes.
// Assumes inclusion by the mode register bank and its bench only.
`ifndef MODE_REG_DEFINES_VH
`define MODE_REG_DEFINES_VH

`define MA_LATENCY        6'h02
`define MA_IO_CFG         6'h03
`define MA_REF_THERM      6'h04
`define MA_MAKER          6'h05
`define MA_REV_FIRST      6'h06
`define MA_REV_SECOND     6'h07
`define MA_GEOMETRY       6'h08
`define MA_VENDOR_TEST    6'h09
`define MA_SET_POINT      6'h0D

`define LAT_WRLEV_BIT     7
`define SP_WRITE_BIT      6
`define SP_ACTIVE_BIT     7

`define IO_PUCAL_BIT      0
`define IO_WRPST_BIT      1
`define IO_PROTECT_BIT    2
`define IO_PULLDOWN_DRIVE_STRENGTH_LSB       3
`define IO_RDINV_BIT      6
`define IO_WRINV_BIT      7
`define IO_CFG_RESET      8'h31

`define RT_RATE_LSB       0
`define RT_ABORT_BIT      3
`define RT_REPAIR_BIT     4
`define RT_OFFSET_LSB     5
`define RT_TUF_BIT        7
`define RT_WR_MASK        8'h78
`define RATE_1X           3'h3
`define RATE_DERATE       3'h6

`define GEOMETRY_DEFAULT  8'h00
`define MAKER_DEFAULT     8'hA5
`define REV_DEFAULT       8'h00

`endif

// *** verilog/mode_reg_bank.v ***
// Mode register bank of one channel: set-point copies, thermal register,
// identity and geometry registers. Assumes a decoder delivers one-cycle
// write and read strobes with a six-bit address and eight-bit operand.
//
// What this block does
// - Write-leveling set holds mode-register-write state until cleared
// - Writes and reads reach write-select set point
// - Leveling and I/O config outputs, except repair protection, follow only the active set point
// - Pull-up calibration point bit, default one
// - Write postamble length bit, default half cycle
// - Pull-down strength code, default 110
// - Read and write inversion enables, default off
// - Repair protection sticky until power-on reset
// - Protection refuses writing one to repair entry
// - Read-only refresh rate field code meanings
// - Rate scales refresh timings; 011 is 85 C
// - Derating needed reports rate code 110
// - Update flag sets on rate change, read clears
// - Flag zero at power-up; rate valid after init
// - Thermal register writes update bits 6..3 only
// - Self-refresh abort enable bit, default off
// - Repair entry bit enters or leaves repair mode
// - Thermal offset field, two bits
// - Geometry type and width codes read 00
// - Density field four bits in geometry register
// - Read data on low eight lanes, rest zero
`timescale 1ns/1ps
`include "mode_reg_defines.vh"

module mode_reg_bank #(
  parameter [7:0] MAKER_CODE    = `MAKER_DEFAULT, // Arbitrary value.
  parameter [7:0] REV_FIRST     = `REV_DEFAULT,   // Arbitrary value.
  parameter [7:0] REV_SECOND    = `REV_DEFAULT,   // Arbitrary value.
  parameter [3:0] DENSITY_CODE  = 4'h0,
  parameter       DQ_WIDTH      = 16
) (
  // Clock and reset.
  input  wire                clk_i,
  input  wire                rst_n_i,
  // Mode register commands.
  input  wire                mrw_i,
  input  wire                mrr_i,
  input  wire [5:0]          addr_i,
  input  wire [7:0]          op_i,
  // Device status inputs.
  input  wire                init_done_i,
  input  wire [2:0]          temp_rate_i,
  input  wire                derate_i,
  // Read data.
  output reg  [DQ_WIDTH-1:0] rd_dq_o,
  output reg                 rd_valid_o,
  // Operating configuration; write leveling and I/O config other than repair protection from the active set point.
  output reg                 wrlev_state_o,
  output reg                 pullup_cal_point_o,
  output reg                 write_postamble_length_o,
  output reg  [2:0]          pulldown_drive_strength_o,
  output reg                 read_inversion_enable_o,
  output reg                 write_inversion_enable_o,
  output reg                 repair_protect_o,
  output reg                 selfrefresh_abort_enable_o,
  output reg                 repair_mode_entry_o,
  output reg  [1:0]          thermal_offset_o,
  output reg  [2:0]          refresh_rate_o
);

  reg  [7:0] io_cfg_r [0:1];
  reg  [7:0] set_point_r;
  reg        lev_r [0:1];
  reg        protect_r;
  reg  [3:0] rt_wr_r;
  reg  [2:0] rate_r;
  reg        tuf_r;
  reg  [7:0] rd_data;
  wire       wsel;
  wire       asel;
  wire [2:0] rate_src;
  wire       tuf_set;
  wire       tuf_clr;

  assign wsel = set_point_r[`SP_WRITE_BIT];
  assign asel = set_point_r[`SP_ACTIVE_BIT];

  // Derating overrides the sensor code so the controller sees 110.
  assign rate_src = !init_done_i ? `RATE_1X :
                    (derate_i ? `RATE_DERATE : temp_rate_i);
  assign tuf_set  = init_done_i && (rate_src != rate_r);
  assign tuf_clr  = mrr_i && (addr_i == `MA_REF_THERM);

  // Set-point copies of write-leveling and I/O config, selected on write.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      io_cfg_r[0] <= `IO_CFG_RESET;
      io_cfg_r[1] <= `IO_CFG_RESET;
      lev_r[0]    <= 1'b0;
      lev_r[1]    <= 1'b0;
      set_point_r <= 8'h00;
      protect_r   <= 1'b0;
      rt_wr_r     <= 4'h0;
    end
    else if (mrw_i)
    begin
      case (addr_i)
        `MA_LATENCY:
          lev_r[wsel] <= op_i[`LAT_WRLEV_BIT];
        `MA_IO_CFG:
        begin
          io_cfg_r[wsel] <= op_i;
          if (op_i[`IO_PROTECT_BIT])
            protect_r <= 1'b1;
        end
        `MA_REF_THERM:
        begin
          // Only bits 6..3 land; repair entry refused when protected.
          rt_wr_r[0] <= op_i[`RT_ABORT_BIT];
          rt_wr_r[2:1] <= op_i[`RT_OFFSET_LSB +: 2];
          if (!(protect_r && op_i[`RT_REPAIR_BIT]))
            rt_wr_r[3] <= op_i[`RT_REPAIR_BIT];
        end
        `MA_SET_POINT:
          set_point_r <= op_i;
        default:
          set_point_r <= set_point_r;
      endcase
    end
  end

  // Refresh rate tracking; a new change beats a read clear.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rate_r <= `RATE_1X;
      tuf_r  <= 1'b0;
    end
    else
    begin
      rate_r <= rate_src;
      if (tuf_set)
        tuf_r <= 1'b1;
      else if (tuf_clr)
        tuf_r <= 1'b0;
    end
  end

  // Read multiplexer; write-only and unmapped addresses read zero.
  always @*
  begin
    rd_data = 8'h00;
    case (addr_i)
      `MA_LATENCY:     rd_data = {lev_r[wsel], 7'h00};
      `MA_IO_CFG:      rd_data = io_cfg_r[wsel];
      `MA_REF_THERM:   rd_data = {tuf_r, rt_wr_r[2:1], rt_wr_r[3],
                                  rt_wr_r[0], rate_r};
      `MA_MAKER:       rd_data = MAKER_CODE;
      `MA_REV_FIRST:   rd_data = REV_FIRST;
      `MA_REV_SECOND:  rd_data = REV_SECOND;
      `MA_GEOMETRY:    rd_data = {2'b00, DENSITY_CODE, 2'b00};
      `MA_SET_POINT:   rd_data = set_point_r;
      default:         rd_data = 8'h00;
    endcase
  end

  // Registered outputs; write leveling and I/O config other than repair protection driven from the active set point.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_dq_o                    <= {DQ_WIDTH{1'b0}};
      rd_valid_o                 <= 1'b0;
      wrlev_state_o              <= 1'b0;
      pullup_cal_point_o         <= 1'b1;
      write_postamble_length_o   <= 1'b0;
      pulldown_drive_strength_o  <= 3'h6;
      read_inversion_enable_o    <= 1'b0;
      write_inversion_enable_o   <= 1'b0;
      repair_protect_o           <= 1'b0;
      selfrefresh_abort_enable_o <= 1'b0;
      repair_mode_entry_o        <= 1'b0;
      thermal_offset_o           <= 2'h0;
      refresh_rate_o             <= `RATE_1X;
    end
    else
    begin
      rd_valid_o <= mrr_i;
      if (mrr_i)
        rd_dq_o <= {{(DQ_WIDTH-8){1'b0}}, rd_data};
      // Leveling stays active until the clearing write lands.
      wrlev_state_o <= lev_r[asel];
      pullup_cal_point_o <= io_cfg_r[asel][`IO_PUCAL_BIT];
      write_postamble_length_o <= io_cfg_r[asel][`IO_WRPST_BIT];
      pulldown_drive_strength_o <=
        io_cfg_r[asel][`IO_PULLDOWN_DRIVE_STRENGTH_LSB +: 3];
      read_inversion_enable_o  <= io_cfg_r[asel][`IO_RDINV_BIT];
      write_inversion_enable_o <= io_cfg_r[asel][`IO_WRINV_BIT];
      repair_protect_o           <= protect_r;
      selfrefresh_abort_enable_o <= rt_wr_r[0];
      repair_mode_entry_o        <= rt_wr_r[3];
      thermal_offset_o           <= rt_wr_r[2:1];
      refresh_rate_o             <= rate_r;
    end
  end

endmodule // mode_reg_bank

// *** tb/mode_reg_bank_assertions.sv ***
// Port checker for the mode register bank.
// Assumes binding to the bank with its default maker code.
`timescale 1ns/1ps
module mode_reg_bank_assertions (
  // Watched ports.
  input wire        clk_i,
  input wire        rst_n_i,
  input wire        mrw_i,
  input wire        mrr_i,
  input wire [5:0]  addr_i,
  input wire        init_done_i,
  input wire        derate_i,
  input wire [15:0] rd_dq_o,
  input wire        rd_valid_o,
  input wire        repair_protect_o,
  input wire        repair_mode_entry_o,
  input wire [2:0]  refresh_rate_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_valid_pulse: assert property (rd_valid_o == $past(mrr_i))
    else $error("read valid not one cycle after read");
  a_upper_zero: assert property (rd_dq_o[15:8] == 8'h00)
    else $error("upper read lanes not zero");
  a_dq_hold: assert property (!mrr_i |=> $stable(rd_dq_o))
    else $error("read data changed without a read");
  a_protect_sticky: assert property (repair_protect_o |=> repair_protect_o)
    else $error("repair protection cleared");
  a_entry_refused: assert property (repair_protect_o && !repair_mode_entry_o
    && mrw_i && addr_i == 6'h04 |=> ##1 !repair_mode_entry_o)
    else $error("repair entry set while protected");
  a_derate_code: assert property ((derate_i && init_done_i) [*4]
    |-> refresh_rate_o == 3'h6)
    else $error("derating not reported");
  a_rate_preinit: assert property (!init_done_i [*3] |-> refresh_rate_o == 3'h3)
    else $error("rate not default before init");
  a_maker_read: assert property (mrr_i && addr_i == 6'h05
    |=> rd_dq_o[7:0] == 8'hA5)
    else $error("maker code read wrong");
endmodule // mode_reg_bank_assertions

// *** tb/mrc_model.sv ***
// Controller model issuing one mode register command per call.
// Assumes the bench calls cmd; strobes move only at falling edges.
`timescale 1ns/1ps
module mrc_model (
  // Clock.
  input  wire       clk_i,
  // Commands.
  output reg        mrw_o,
  output reg        mrr_o,
  output reg  [5:0] addr_o,
  output reg  [7:0] op_o
);
  // Tracks write leveling; while set, only the clearing write to 02 is issued.
  reg lev_r = 1'b0;
  initial
  begin
    mrw_o = 1'b0;
    mrr_o = 1'b0;
    addr_o = 6'h00;
    op_o = 8'h00;
  end
  task cmd(input w, input [5:0] a, input [7:0] d);
    begin
      @(negedge clk_i);
      if (!lev_r || (w && a == 6'h02 && !d[7]))
      begin
        mrw_o = w;
        mrr_o = !w;
        addr_o = a;
        op_o = d;
        if (w && a == 6'h02) lev_r = d[7];
      end
      @(negedge clk_i);
      mrw_o = 1'b0;
      mrr_o = 1'b0;
      // Idle lines toggle so stale values are never mistaken for data.
      addr_o = ~addr_o;
      op_o = ~op_o;
      @(negedge clk_i);
    end
  endtask
endmodule // mrc_model

// *** tb/lpddr4_mode_register_set_tb.sv ***
// Bench for the mode register bank driven by the controller model.
// Assumes the bank, model and checker are compiled first.
`timescale 1ns/1ps
module lpddr4_mode_register_set_tb;
  reg         clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         init_done_i = 1'b0;
  reg  [2:0]  temp_rate_i = 3'h1;
  reg         derate_i = 1'b0;
  wire        mrw_i, mrr_i, rd_valid_o, wrlev_state_o, pullup_cal_point_o;
  wire        write_postamble_length_o, read_inversion_enable_o;
  wire        write_inversion_enable_o, repair_protect_o;
  wire        selfrefresh_abort_enable_o, repair_mode_entry_o;
  wire [5:0]  addr_i;
  wire [7:0]  op_i;
  wire [15:0] rd_dq_o;
  wire [2:0]  pulldown_drive_strength_o, refresh_rate_o;
  wire [1:0]  thermal_offset_o;
  wire [7:0]  cfg = {write_inversion_enable_o, read_inversion_enable_o,
    pulldown_drive_strength_o, repair_protect_o, write_postamble_length_o,
    pullup_cal_point_o};
  reg  [22:0] rows [0:7];
  integer     failures = 0;
  integer     num_checks = 0;
  integer     i;
  always #5 clk_i = ~clk_i;
  mrc_model cm (.clk_i(clk_i), .mrw_o(mrw_i), .mrr_o(mrr_i),
    .addr_o(addr_i), .op_o(op_i));
  mode_reg_bank dut (.*);
  task chk(input [8*8-1:0] nm, input [7:0] e, input [7:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("[ERR] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    failures = failures + 1;
    finish_test;
  end
  initial
  begin
    rows[0] = {1'b0, 6'h05, 8'h00, 8'hA5};
    rows[1] = {1'b1, 6'h05, 8'hFF, 8'h00};
    rows[2] = {1'b0, 6'h05, 8'h00, 8'hA5};
    rows[3] = {1'b0, 6'h06, 8'h00, 8'h00};
    rows[4] = {1'b0, 6'h08, 8'h00, 8'h00};
    rows[5] = {1'b1, 6'h04, 8'hFF, 8'h00};
    rows[6] = {1'b0, 6'h04, 8'h00, 8'h7B};
    rows[7] = {1'b0, 6'h0A, 8'h00, 8'h00};
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk("config", 8'h31, cfg);
    for (i = 0; i < 8; i = i + 1)
    begin
      cm.cmd(rows[i][22], rows[i][21:16], rows[i][15:8]);
      if (!rows[i][22]) chk("rd_dq", rows[i][7:0], rd_dq_o[7:0]);
    end
    $display("test rows done");
    init_done_i = 1'b1;
    repeat (4) @(negedge clk_i);
    cm.cmd(1'b0, 6'h04, 8'h00);
    chk("thermal", 8'hF9, rd_dq_o[7:0]);
    cm.cmd(1'b0, 6'h04, 8'h00);
    chk("thermal", 8'h79, rd_dq_o[7:0]);
    derate_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("rate", 8'h06, refresh_rate_o);
    derate_i = 1'b0;
    $display("test thermal done");
    cm.cmd(1'b1, 6'h04, 8'h10);
    chk("entry", 8'h01, repair_mode_entry_o);
    cm.cmd(1'b1, 6'h04, 8'h48);
    chk("offset", 8'h02, thermal_offset_o);
    chk("abort", 8'h01, selfrefresh_abort_enable_o);
    chk("entry", 8'h00, repair_mode_entry_o);
    cm.cmd(1'b1, 6'h04, 8'h00);
    chk("abort", 8'h00, selfrefresh_abort_enable_o);
    cm.cmd(1'b1, 6'h03, 8'hC3);
    chk("config", 8'hC3, cfg);
    cm.cmd(1'b1, 6'h0D, 8'h40);
    cm.cmd(1'b1, 6'h03, 8'h00);
    chk("config", 8'hC3, cfg);
    cm.cmd(1'b1, 6'h0D, 8'hC0);
    chk("config", 8'h00, cfg);
    cm.cmd(1'b1, 6'h0D, 8'h00);
    cm.cmd(1'b1, 6'h03, 8'h04);
    cm.cmd(1'b1, 6'h03, 8'h00);
    chk("config", 8'h04, cfg);
    cm.cmd(1'b1, 6'h04, 8'h10);
    chk("entry", 8'h00, repair_mode_entry_o);
    $display("test set point done");
    cm.cmd(1'b1, 6'h02, 8'h80);
    chk("wrlev", 8'h01, wrlev_state_o);
    cm.cmd(1'b0, 6'h05, 8'h00);
    cm.cmd(1'b1, 6'h02, 8'h00);
    chk("wrlev", 8'h00, wrlev_state_o);
    rst_n_i = 1'b0;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk("config", 8'h31, cfg);
    $display("test reset done");
    finish_test;
  end
endmodule // lpddr4_mode_register_set_tb
bind mode_reg_bank mode_reg_bank_assertions chk_u (.*);
